// ---- hdl/hbdq_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module hbdq_top
  import hbdq_pkg::*;
#(
  parameter int DEPTH = IOQ_DEPTH,
  parameter int DEFERS = DEFER_MAX
)
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // processor request (already captured at 2x, both address phases)
  input wire logic req_valid_in,
  input wire logic req_is_io_in,
  input wire logic req_defer_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  output logic req_throttle_out,
  // retirement of the oldest queue entry
  input wire logic retire_in,
  // deferred completion per target interface
  input wire logic [2:0] defer_done_in,
  // head of queue, routed
  output logic head_valid_out,
  output logic [1:0] head_target_out,
  output logic [ADDR_W-1:0] head_line_out,
  output logic [3:0] ioq_count_out,
  output logic [1:0] defer_count_out,
  // quad pumped data with dynamic bus inversion
  input wire logic [63:0] dat_raw_in,
  input wire logic [3:0] dat_inv_in,
  output logic [63:0] dat_clean_out,
  input wire logic [63:0] dat_tx_in,
  output logic [63:0] dat_tx_out,
  output logic [3:0] dat_inv_out,
  // inbound accesses to dram
  input wire logic in_valid_in,
  input wire logic in_from_hub_in,
  input wire logic in_framed_in,
  input wire logic [ADDR_W-1:0] in_addr_in,
  input wire logic in_write_in,
  input wire logic [GART_W-1:0] gart_page_in,
  output logic snoop_out,
  output logic irq_to_bus_out,
  output logic [ADDR_W-1:0] in_xlat_out,
  // arbitration among initiators
  input wire logic [ARB_N-1:0] arb_req_in,
  output logic [ARB_N-1:0] arb_gnt_out
);
  // refuse sizes that the 4-bit queue and 2-bit defer counters cannot hold
  if (DEPTH < 1 || DEPTH > 15 || DEFERS < 1 || DEFERS > 3)
  begin : g_bad_size
    $error("hbdq_top: unsupported depth or defer limit");
  end

  // one processor agent only; bus rate fixed, no parity pins exist

  // queue storage
  logic [ADDR_W-1:0] addr_mem [DEPTH];
  logic [1:0] tgt_mem [DEPTH];
  logic [3:0] wr_q, rd_q, cnt_q;
  logic [1:0] dcnt_q;
  logic [2:0] dbusy_q;

  // decode of the incoming processor cycle
  wire cfg_hit = req_is_io_in && ((req_addr_in & CFG_IO_MASK) == CFG_IO_ADDR);
  wire gio_hit = req_is_io_in && ((req_addr_in & GFX_IO_MASK_RST) == GFX_IO_BASE_RST);
  wire gmem_hit = !req_is_io_in && ((req_addr_in & GFX_MEM_MASK_RST) == GFX_MEM_BASE_RST);
  wire [1:0] dec_tgt = cfg_hit ? HBDQ_TGT_CFG :
                       (gio_hit | gmem_hit) ? HBDQ_TGT_GFX :
                       HBDQ_TGT_HUB;

  // deferral gate: total limit and one per interface
  wire defer_ok = (dcnt_q < DEFERS[1:0]) && !dbusy_q[dec_tgt];
  wire full = (cnt_q == DEPTH[3:0]);
  assign req_throttle_out = full || (req_defer_in && !defer_ok);
  wire push = req_valid_in && !req_throttle_out;
  wire pop = retire_in && (cnt_q != 4'h0);
  wire [3:0] wr_nx = (wr_q == DEPTH[3:0] - 4'h1) ? 4'h0 : wr_q + 4'h1;
  wire [3:0] rd_nx = (rd_q == DEPTH[3:0] - 4'h1) ? 4'h0 : rd_q + 4'h1;
  wire dpush = push && req_defer_in;
  wire [2:0] dset = dpush ? (3'h1 << dec_tgt) : 3'h0;
  wire [2:0] dclr = defer_done_in & dbusy_q;
  wire [1:0] dclr_n = 2'(dclr[0]) + 2'(dclr[1]) + 2'(dclr[2]);

  // queue pointers; push and pop may coincide
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      wr_q <= 4'h0;
      rd_q <= 4'h0;
      cnt_q <= 4'h0;
    end
    else
    begin
      if (push) wr_q <= wr_nx;
      if (pop) rd_q <= rd_nx;
      cnt_q <= cnt_q + 4'(push) - 4'(pop);
    end
  end

  // entry store, line aligned to the coherency unit
  always_ff @(posedge ref_clk_in)
  begin
    if (push)
    begin
      addr_mem[wr_q] <= {req_addr_in[ADDR_W-1:LINE_LSB], {LINE_LSB{1'b0}}};
      tgt_mem[wr_q] <= dec_tgt;
    end
  end

  // deferred tracking; a new deferral wins over a clear
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      dbusy_q <= 3'h0;
      dcnt_q <= 2'h0;
    end
    else
    begin
      dbusy_q <= (dbusy_q & ~dclr) | dset;
      dcnt_q <= dcnt_q + 2'(dpush) - dclr_n;
    end
  end

  assign head_valid_out = (cnt_q != 4'h0);
  assign head_target_out = head_valid_out ? tgt_mem[rd_q] : 2'h0;
  assign head_line_out = head_valid_out ? addr_mem[rd_q] : '0;
  assign ioq_count_out = cnt_q;
  assign defer_count_out = dcnt_q;

  // inversion per 16-bit group; data beats arrive at 4x, addresses at 2x
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_dbi
      wire [4:0] ones = 5'($countones(dat_tx_in[16*g +: 16]));
      wire inv = ones > 5'h08;
      logic [15:0] rx_q, tx_q;
      logic inv_q;
      always_ff @(posedge ref_clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
        begin
          rx_q <= 16'h0;
          tx_q <= 16'h0;
          inv_q <= 1'b0;
        end
        else
        begin
          rx_q <= dat_inv_in[g] ? ~dat_raw_in[16*g +: 16] : dat_raw_in[16*g +: 16];
          tx_q <= inv ? ~dat_tx_in[16*g +: 16] : dat_tx_in[16*g +: 16];
          inv_q <= inv;
        end
      end
      assign dat_clean_out[16*g +: 16] = rx_q;
      assign dat_tx_out[16*g +: 16] = tx_q;
      assign dat_inv_out[g] = inv_q;
    end
  endgenerate

  // inbound snoop policy, aperture remap, interrupt redirection
  wire aper_hit = (in_addr_in & APER_MASK_RST) == APER_BASE_RST;
  wire msi_hit = in_write_in && ((in_addr_in & MSI_MASK) == MSI_BASE);
  wire snoop_d = in_valid_in && !msi_hit && (in_from_hub_in || in_framed_in);
  wire [ADDR_W-1:0] xlat_d = aper_hit ? {gart_page_in, in_addr_in[11:0]} : in_addr_in;
  logic snoop_q, irq_q;
  logic [ADDR_W-1:0] xlat_q;
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      snoop_q <= 1'b0;
      irq_q <= 1'b0;
      xlat_q <= '0;
    end
    else
    begin
      snoop_q <= snoop_d;
      irq_q <= in_valid_in && msi_hit;
      xlat_q <= xlat_d;
    end
  end
  assign snoop_out = snoop_q;
  assign irq_to_bus_out = irq_q;
  assign in_xlat_out = xlat_q;

  // round-robin arbiter, grant held while request stays
  logic [ARB_N-1:0] gnt_q;
  logic [1:0] last_q;
  logic [ARB_N-1:0] pick;
  logic [1:0] pick_i;
  always_comb
  begin
    pick = '0;
    pick_i = last_q;
    for (int k = ARB_N; k >= 1; k--)
    begin
      if (arb_req_in[2'(last_q + 2'(k))])
      begin
        pick = '0;
        pick[2'(last_q + 2'(k))] = 1'b1;
        pick_i = 2'(last_q + 2'(k));
      end
    end
  end
  wire keep = |(gnt_q & arb_req_in);
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      gnt_q <= '0;
      last_q <= 2'h3;
    end
    else if (!keep)
    begin
      gnt_q <= pick;
      if (|pick) last_q <= pick_i;
    end
  end
  assign arb_gnt_out = gnt_q;
endmodule
`default_nettype wire

// ---- common/hbdq_pkg.sv ----
package hbdq_pkg;
  // in-order queue depth and deferred limits
  localparam int IOQ_DEPTH = 12;
  localparam int DEFER_MAX = 2;
  localparam int ADDR_W = 32;
  localparam int LINE_BYTES = 64;
  localparam int LINE_LSB = 6;
  localparam int ADDR_PHASES = 2;
  localparam int DATA_PHASES = 4;
  localparam int BUS_MTS = 400;
  // targets of a decoded cycle
  typedef enum logic [1:0]
  {
    HBDQ_TGT_HUB = 2'b00,
    HBDQ_TGT_GFX = 2'b01,
    HBDQ_TGT_CFG = 2'b10
  } hbdq_tgt_t;
  // arbitration requester indices
  localparam int ARB_CPU = 0;
  localparam int ARB_MEM = 1;
  localparam int ARB_GFX = 2;
  localparam int ARB_HUB = 3;
  localparam int ARB_N = 4;
  // config space window and default aperture
  localparam logic [31:0] CFG_IO_ADDR = 32'h0000_0CF8;
  localparam logic [31:0] CFG_IO_MASK = 32'hFFFF_FFF8;
  localparam logic [31:0] APER_BASE_RST = 32'hE000_0000;
  localparam logic [31:0] APER_MASK_RST = 32'hF000_0000;
  localparam logic [31:0] GFX_MEM_BASE_RST = 32'hD000_0000;
  localparam logic [31:0] GFX_MEM_MASK_RST = 32'hF000_0000;
  localparam logic [31:0] GFX_IO_BASE_RST = 32'h0000_D000;
  localparam logic [31:0] GFX_IO_MASK_RST = 32'hFFFF_F000;
  localparam logic [31:0] MSI_BASE = 32'hFEE0_0000;
  localparam logic [31:0] MSI_MASK = 32'hFFF0_0000;
  localparam int GART_W = 20;
endpackage

// ---- testbench/hbdq_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module hbdq_props
  import hbdq_pkg::*;
#(
  parameter int DEPTH = IOQ_DEPTH,
  parameter int DEFERS = DEFER_MAX
)
(
  // queue side
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic req_valid_in,
  input wire logic retire_in,
  input wire logic req_throttle_out,
  input wire logic head_valid_out,
  input wire logic [ADDR_W-1:0] head_line_out,
  input wire logic [3:0] ioq_count_out,
  input wire logic [1:0] defer_count_out,
  // inbound and arbiter
  input wire logic in_valid_in,
  input wire logic in_from_hub_in,
  input wire logic in_framed_in,
  input wire logic in_write_in,
  input wire logic snoop_out,
  input wire logic [ARB_N-1:0] arb_req_in,
  input wire logic [ARB_N-1:0] arb_gnt_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  // queue accounting
  AST_FULL: assert property (int'(ioq_count_out) == DEPTH |-> req_throttle_out)
    else $error("full not throttled");
  AST_PUSH: assert property (req_valid_in && !req_throttle_out && !retire_in |=>
    ioq_count_out == $past(ioq_count_out) + 4'h1) else $error("push lost");
  AST_DEPTH: assert property (int'(ioq_count_out) <= DEPTH) else $error("overfill");
  AST_DEFER: assert property (int'(defer_count_out) <= DEFERS) else $error("defers");
  AST_LINE: assert property (head_valid_out |-> head_line_out[5:0] == 6'h00)
    else $error("unaligned");
  // snoop policy, one cycle after the access
  AST_NATIVE: assert property (in_valid_in && !in_from_hub_in && !in_framed_in
    |=> !snoop_out) else $error("native snooped");
  AST_HUBRD: assert property (in_valid_in && in_from_hub_in && !in_write_in
    |=> snoop_out) else $error("hub not snooped");
  // grant only to last cycle's requester
  AST_GNT: assert property (arb_gnt_out != 4'h0 |-> $onehot(arb_gnt_out) &&
    (arb_gnt_out & $past(arb_req_in)) != 4'h0) else $error("bad grant");
endmodule
`default_nettype wire

// ---- testbench/hbdq_cpu.sv ----
`timescale 1ns/1ps
`default_nettype none
module hbdq_cpu
  import hbdq_pkg::*;
(
  // control from bench
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic go_in,
  input wire logic [3:0] n_in,
  input wire logic [ADDR_W-1:0] base_in,
  // bus side
  input wire logic throttle_in,
  output logic valid_out,
  output logic [ADDR_W-1:0] addr_out
);
  logic [3:0] left_q;
  // lone agent, holds each request until taken
  always_ff @(posedge ref_clk_in or negedge nrst_in)
    if (!nrst_in)
      left_q <= 4'h0;
    else if (go_in)
      left_q <= n_in;
    else if (valid_out && !throttle_in)
      left_q <= left_q - 4'h1;
  // idle shows inverted base, never a stale address
  assign valid_out = left_q != 4'h0;
  assign addr_out = valid_out ? base_in + {22'h0, left_q - 4'h1, 6'h00} : ~base_in;
endmodule
`default_nettype wire

// ---- testbench/tb_host_bus_decode_queue.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_host_bus_decode_queue;
  import hbdq_pkg::*;
  logic ref_clk_in = '0, nrst_in = '0, req_is_io_in = '0, req_defer_in = '0, retire_in = '0;
  logic in_valid_in = '0, in_from_hub_in = '0, in_framed_in = '0, in_write_in = '0, go = '0;
  logic [2:0] defer_done_in = '0;
  logic [3:0] dat_inv_in = '0, arb_req_in = '0, n = '0, dat_inv_out, arb_gnt_out, ioq_count_out;
  logic [31:0] in_addr_in = '0, base = '0, req_addr_in, head_line_out, in_xlat_out;
  logic [63:0] dat_raw_in = '0, dat_tx_in = '0, dat_clean_out, dat_tx_out;
  logic [19:0] gart_page_in = 20'hABCDE;
  logic [1:0] head_target_out, defer_count_out;
  logic req_valid_in, req_throttle_out, head_valid_out, snoop_out, irq_to_bus_out;
  int num_errors = 0, num_checks = 0, cyc = 0;
  hbdq_top u_hbdq_top (.*);
  hbdq_cpu u_hbdq_cpu (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .go_in(go), .n_in(n),
    .base_in(base), .throttle_in(req_throttle_out), .valid_out(req_valid_in),
    .addr_out(req_addr_in));
  // clock and hang guard
  initial forever #12.5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(logic [67:0] got, logic [67:0] exp);
    num_checks++;
    if (got !== exp)
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    if (got !== exp)
      num_errors++;
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge ref_clk_in);
    #1;
  endtask
  // model loads k requests from base
  task automatic send(logic [31:0] b, logic [3:0] k, logic i, logic d);
    @(posedge ref_clk_in);
    {base, n, req_is_io_in, req_defer_in, go} <= {b, k, i, d, 1'h1};
    @(posedge ref_clk_in);
    go <= 1'h0;
  endtask
  task automatic pop(int k);
    repeat (k) @(posedge ref_clk_in) retire_in <= 1'h1;
    @(posedge ref_clk_in);
    retire_in <= 1'h0;
    #1;
  endtask
  // thirteen requests against twelve entries
  task automatic t_fill();
    send(32'h1000_0000, 4'hD, 1'h0, 1'h0);
    tick(13);
    chk(req_throttle_out, 1'h1);
    chk(head_line_out, 32'h1000_0300);
    pop(1);
    tick(1);
    chk(ioq_count_out, 4'hC);
    pop(12);
    chk(head_valid_out, 1'h0);
  endtask
  // two deferred cycles to one interface
  task automatic t_defer();
    send(32'h1000_0000, 4'h1, 1'h0, 1'h1);
    send(32'h2000_0000, 4'h1, 1'h0, 1'h1);
    tick(2);
    chk({req_throttle_out, defer_count_out, ioq_count_out}, 7'h51);
    // hub completion frees its slot, then a second interface fills the total
    @(posedge ref_clk_in);
    defer_done_in <= 3'h1;
    @(posedge ref_clk_in);
    defer_done_in <= 3'h0;
    send(32'hD000_0000, 4'h1, 1'h0, 1'h1);
    send(32'h0000_0CF8, 4'h1, 1'h1, 1'h1);
    tick(2);
    chk({req_throttle_out, defer_count_out, ioq_count_out}, 7'h63);
  endtask
  // positive decode targets first, then the subtractive hub
  task automatic t_route();
    send(32'h0000_0CF8, 4'h1, 1'h1, 1'h0);
    send(32'hD000_0000, 4'h1, 1'h0, 1'h0);
    send(32'h0000_D000, 4'h1, 1'h1, 1'h0);
    send(32'h0000_0080, 4'h1, 1'h1, 1'h0);
    tick(1);
    chk(head_target_out, HBDQ_TGT_CFG);
    pop(1);
    chk(head_target_out, HBDQ_TGT_GFX);
    pop(1);
    chk(head_target_out, HBDQ_TGT_GFX);
    pop(1);
    chk(head_target_out, HBDQ_TGT_HUB);
    pop(1);
  endtask
  // inversion per group, then a round-robin turn past the last winner
  task automatic t_data();
    @(posedge ref_clk_in);
    {dat_tx_in, dat_raw_in, dat_inv_in, arb_req_in} <= {64'h00FF_0000_0000_FFFF, 64'h0, 8'h96};
    tick(2);
    chk(dat_tx_out, 64'h00FF_0000_0000_0000);
    chk({dat_inv_out, dat_clean_out}, 68'h1_FFFF_0000_0000_FFFF);
    chk(arb_gnt_out, 4'h2);
    @(posedge ref_clk_in);
    arb_req_in <= 4'h5;
    tick(1);
    chk(arb_gnt_out, 4'h4);
  endtask
  task automatic t_in(logic h, logic f, logic w, logic [31:0] a, logic [33:0] e);
    @(posedge ref_clk_in);
    {in_valid_in, in_from_hub_in, in_framed_in, in_write_in, in_addr_in} <= {1'h1, h, f, w, a};
    @(posedge ref_clk_in);
    in_valid_in <= 1'h0;
    #1;
    chk({snoop_out, irq_to_bus_out, in_xlat_out}, e);
  endtask
  initial
  begin
    repeat (16) @(posedge ref_clk_in);
    nrst_in <= 1'h1;
    t_fill();
    t_route();
    t_defer();
    t_in(1'h1, 1'h0, 1'h0, 32'h0000_1000, 34'h2_0000_1000);
    t_in(1'h0, 1'h0, 1'h0, 32'hE000_1234, 34'h0_ABCD_E234);
    t_in(1'h1, 1'h0, 1'h1, 32'hFEE0_0000, 34'h1_FEE0_0000);
    t_in(1'h0, 1'h1, 1'h0, 32'h0000_2000, 34'h2_0000_2000);
    t_data();
    report_and_stop();
  end
endmodule
bind hbdq_top hbdq_props #(.DEPTH(DEPTH), .DEFERS(DEFERS)) u_hbdq_props (.*);
`default_nettype wire
